// ### tap_sequencer.sv
// test access sequencer: divides ref_clk into a test clock, runs test resets and shifts
// assumes tdo arrives from another timing domain and is synchronised here
module tap_sequencer (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // command side
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_reset,
    input wire logic [trace_attach_pkg::BIT_W-1:0] cmd_count,
    input wire logic [trace_attach_pkg::SHIFT_W-1:0] cmd_tms,
    input wire logic [trace_attach_pkg::SHIFT_W-1:0] cmd_tdi,
    output logic done,
    output logic [trace_attach_pkg::SHIFT_W-1:0] tdo_bits,
    // test access pins
    output trace_attach_pkg::tap_pins_s tap_out,
    input wire logic tdo
);
    trace_attach_pkg::seq_state_s st_r;
    trace_attach_pkg::seq_state_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tdo_s1 = tdo;
        st_nxt.tdo_s2 = st_r.tdo_s1;
        case (st_r.state)
            trace_attach_pkg::SEQ_IDLE: begin
                if (cmd_valid) begin
                    if (cmd_reset) begin
                        // clock stopped low, mode select high, reset asserted
                        st_nxt.state = trace_attach_pkg::SEQ_RST_HOLD;
                        st_nxt.tck = 1'b0; // R19
                        st_nxt.tms = 1'b1; // R19
                        st_nxt.test_reset_n = 1'b0;
                        st_nxt.cnt = trace_attach_pkg::TRST_HOLD_CNT;
                    end else begin
                        st_nxt.state = trace_attach_pkg::SEQ_SHIFT_LO;
                        st_nxt.bits_left = cmd_count;
                        st_nxt.tms_sh = cmd_tms;
                        st_nxt.tdi_sh = cmd_tdi;
                        st_nxt.tdo_sh = '0;
                        st_nxt.tms = cmd_tms[0];
                        st_nxt.tdi = cmd_tdi[0];
                        st_nxt.cnt = trace_attach_pkg::TCK_HALF_CNT;
                    end
                end
            end
            trace_attach_pkg::SEQ_RST_HOLD: begin
                if (st_r.cnt == trace_attach_pkg::CNT_ZERO) begin
                    // release while the test clock is stopped
                    st_nxt.test_reset_n = 1'b1; // R19
                    st_nxt.cnt = trace_attach_pkg::SETTLE_CNT;
                    st_nxt.state = trace_attach_pkg::SEQ_RST_SETTLE;
                end else begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end
            end
            trace_attach_pkg::SEQ_RST_SETTLE: begin
                if (st_r.cnt == trace_attach_pkg::CNT_ZERO) begin
                    st_nxt.state = trace_attach_pkg::SEQ_DONE;
                end else begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end
            end
            trace_attach_pkg::SEQ_SHIFT_LO: begin
                if (st_r.cnt == trace_attach_pkg::CNT_ZERO) begin
                    st_nxt.tdo_sh = {st_r.tdo_s2, st_r.tdo_sh[trace_attach_pkg::SHIFT_W-1:1]};
                    st_nxt.tck = 1'b1;
                    // external chain stage moves only with the rising test clock
                    st_nxt.ext_chain = st_r.tdi; // R22
                    st_nxt.cnt = trace_attach_pkg::TCK_HALF_CNT;
                    st_nxt.state = trace_attach_pkg::SEQ_SHIFT_HI;
                end else begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end
            end
            trace_attach_pkg::SEQ_SHIFT_HI: begin
                if (st_r.cnt == trace_attach_pkg::CNT_ZERO) begin
                    st_nxt.tck = 1'b0;
                    st_nxt.cnt = trace_attach_pkg::TCK_HALF_CNT;
                    if (st_r.bits_left == trace_attach_pkg::BIT_ZERO) begin
                        st_nxt.state = trace_attach_pkg::SEQ_DONE;
                    end else begin
                        st_nxt.bits_left = st_r.bits_left - 1'b1;
                        st_nxt.tms_sh = st_r.tms_sh >> 1;
                        st_nxt.tdi_sh = st_r.tdi_sh >> 1;
                        st_nxt.tms = st_r.tms_sh[1];
                        st_nxt.tdi = st_r.tdi_sh[1];
                        st_nxt.state = trace_attach_pkg::SEQ_SHIFT_LO;
                    end
                end else begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end
            end
            trace_attach_pkg::SEQ_DONE: begin
                st_nxt.state = trace_attach_pkg::SEQ_IDLE;
            end
            default: begin
                st_nxt.state = trace_attach_pkg::SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.state <= trace_attach_pkg::SEQ_IDLE;
            st_r.tms <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cmd_ready = (st_r.state == trace_attach_pkg::SEQ_IDLE);
    assign done = (st_r.state == trace_attach_pkg::SEQ_DONE);
    assign tdo_bits = st_r.tdo_sh;
    always_comb begin
        // expansion data first, so the far side never sees the clock edge before it
        tap_out.chain_expansion_in = st_r.ext_chain; // R22
        tap_out.tck = st_r.tck;
        tap_out.tms = st_r.tms;
        tap_out.tdi = st_r.tdi;
        tap_out.test_reset_n = st_r.test_reset_n;
        // test clock divided from ref_clk and stopped between commands
        tap_out.jtag_clock_enable = 1'b1; // R16
    end

    // helper: cycles the test clock has been high
    logic [trace_attach_pkg::CNT_W-1:0] hi_cnt;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_cnt <= '0;
        end else if (st_r.tck) begin
            hi_cnt <= hi_cnt + 1'b1;
        end else begin
            hi_cnt <= '0;
        end
    end

    trst_tms_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R19
        !tap_out.test_reset_n |-> tap_out.tms)
        else $error("mode select low during test reset");
    trst_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R19
        $rose(tap_out.test_reset_n) |-> !tap_out.tck && !$past(tap_out.tck))
        else $error("test reset released with clock running");
    tck_en_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
        tap_out.jtag_clock_enable)
        else $error("test clock enable not held high");
    chain_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R22
        $changed(tap_out.chain_expansion_in) |-> $rose(tap_out.tck))
        else $error("expansion data changed away from rising test clock");
    tck_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(tap_out.tck) |-> tap_out.tck [*4] ##1 !tap_out.tck)
        else $error("test clock high phase not four cycles");
    hold_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R19
        $fell(tap_out.test_reset_n) |-> !tap_out.test_reset_n [*8])
        else $error("test reset held too briefly");
    hi_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hi_cnt <= 4'h4)
        else $error("test clock stuck high");
    cover_reset_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(tap_out.test_reset_n));
    cover_shift_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(tap_out.tck) ##[1:20] done);
endmodule

// ### trace_attach_pkg.sv
// shared constants, carriers and state types for the trace attachment host
// assumes a single 50 MHz ref_clk; test clock is derived from it by a divider
package trace_attach_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // test clock half period, a least time, so rounded up
    localparam int TCK_HALF_NS = 80;
    localparam int TCK_HALF_CYC = (TCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // test reset hold and settle time after release, least times
    localparam int TRST_HOLD_NS = 200;
    localparam int TRST_HOLD_CYC = (TRST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_NS = 100;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam int BIT_W = 5;
    localparam int DATA_W = 32;
    localparam int SHIFT_W = 32;
    localparam logic [CNT_W-1:0] TCK_HALF_CNT = CNT_W'(TCK_HALF_CYC - 1);
    localparam logic [CNT_W-1:0] TRST_HOLD_CNT = CNT_W'(TRST_HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(SETTLE_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [BIT_W-1:0] BIT_ZERO = 5'h00;
    localparam logic [1:0] SYNC_CLEAR = 2'h0;

    // core data-side control outputs seen by the glue
    typedef struct packed {
        logic data_request_n;
        logic data_sequential;
        logic data_write_not_read;
        logic condition_pass_flag;
    } core_ctl_s;

    // constant inputs of the trace unit that this core cannot provide
    typedef struct packed {
        logic instruction_valid_in;
        logic fetch_addr0;
        logic java_state_bit;
        logic java_first_fetch;
        logic java_last_fetch;
    } tie_s;

    // test access pins driven toward the trace unit
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic test_reset_n;
        logic jtag_clock_enable;
        logic chain_expansion_in;
    } tap_pins_s;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_RST_HOLD,
        SEQ_RST_SETTLE,
        SEQ_SHIFT_LO,
        SEQ_SHIFT_HI,
        SEQ_DONE
    } seq_state_e;

    typedef struct packed {
        logic read_data_select;
        logic copro_store_select;
        logic copro_seq_select;
    } glue_state_s;

    typedef struct packed {
        seq_state_e state;
        logic [CNT_W-1:0] cnt;
        logic [BIT_W-1:0] bits_left;
        logic [SHIFT_W-1:0] tms_sh;
        logic [SHIFT_W-1:0] tdi_sh;
        logic [SHIFT_W-1:0] tdo_sh;
        logic tck;
        logic tms;
        logic tdi;
        logic test_reset_n;
        logic ext_chain;
        logic tdo_s1;
        logic tdo_s2;
    } seq_state_s;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] trst_sync;
    } top_state_s;
endpackage

// ### copro_select_glue.sv
// registered coprocessor select glue and data bus steering
// assumes core and coprocessor sit on ref_clk; rst_n is already synchronised
module copro_select_glue (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // core side
    input wire trace_attach_pkg::core_ctl_s core_ctl,
    input wire logic [trace_attach_pkg::DATA_W-1:0] mem_rdata,
    input wire logic [trace_attach_pkg::DATA_W-1:0] core_wdata,
    input wire logic [trace_attach_pkg::DATA_W-1:0] copro_rdata,
    // steered buses and selects
    output logic [trace_attach_pkg::DATA_W-1:0] read_data_bus,
    output logic [trace_attach_pkg::DATA_W-1:0] write_data_bus,
    output logic [trace_attach_pkg::DATA_W-1:0] core_read_in,
    output trace_attach_pkg::glue_state_s sel
);
    trace_attach_pkg::glue_state_s st_r;
    trace_attach_pkg::glue_state_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.read_data_select = ~(core_ctl.data_request_n & core_ctl.data_sequential)
            & ~core_ctl.data_write_not_read; // R6
        st_nxt.copro_store_select = ~core_ctl.data_request_n & ~core_ctl.condition_pass_flag; // R7
        st_nxt.copro_seq_select = core_ctl.data_request_n & core_ctl.data_sequential; // R8
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // coprocessor output mirrored onto the buses the trace unit samples
    assign read_data_bus = st_r.read_data_select ? copro_rdata : mem_rdata; // R5
    assign write_data_bus = st_r.copro_store_select ? copro_rdata : core_wdata; // R5
    assign core_read_in = st_r.copro_seq_select ? copro_rdata : mem_rdata;
    assign sel = st_r;

    // read select as it must stand one cycle later
    logic read_sel_exp;
    assign read_sel_exp = ~(core_ctl.data_request_n & core_ctl.data_sequential) & ~core_ctl.data_write_not_read;

    read_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
        1'b1 |=> sel.read_data_select == $past(read_sel_exp))
        else $error("read select does not follow request and direction");
    store_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
        (!core_ctl.data_request_n && !core_ctl.condition_pass_flag) |=> sel.copro_store_select)
        else $error("store select missed a coprocessor transfer");
    seq_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
        !(core_ctl.data_request_n && core_ctl.data_sequential) |=> !sel.copro_seq_select)
        else $error("sequential select set without idle sequential cycle");
    copro_mirror_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
        sel.read_data_select |-> read_data_bus == copro_rdata)
        else $error("coprocessor data not on read bus");
    cover_copro_store_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        sel.copro_store_select && write_data_bus == copro_rdata);
endmodule

// ### trace_attach_host.sv
// top of the host that attaches a core and a test access driver to a trace unit
// assumes core signals share ref_clk; tdo comes back from the trace unit pins
// Functional notes
// R1 - tie instruction valid input high when the core lacks that output
// R2 - trace unit samples read bus while direction shows a read
// R3 - trace unit samples read bus on coprocessor transfers with request and pass low
// R4 - trace unit samples write bus in all other cycles
// R5 - coprocessor memory data must appear on the sampled bus
// R6 - read select registers not(request and sequential) and not write, each edge
// R7 - store select registers not request and not condition pass, each edge
// R8 - sequential select registers request and sequential, each edge
// R9 - tie fetch address bit 0 and java inputs low when absent
// R10 - trace unit main logic acts on rising main clock only
// R11 - trace unit samples core inputs only while core clock enable high
// R12 - trace unit outputs move on rising edge, even with enable low
// R13 - trace state reset clears state and fifo, keeps control register
// R14 - drive trace state reset from the test reset, not core reset; resetn also clears its sync flops here, so core reset asserts it
// R15 - synchronise the test reset into the main clock domain first
// R16 - tie test clock enable high for free-running asynchronous test clock
// R17 - trace unit synchronises every crossing between its two clocks
// R18 - test reset clears test state machine and main control register
// R19 - hold mode select high in test reset; release with clock stopped
// R20 - trace unit passes expansion input to data out off its own chain
// R21 - trace unit data out moves on rising test clock with enable high
// R22 - expansion input source changes only around rising test clock
module trace_attach_host (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // core side
    input wire trace_attach_pkg::core_ctl_s core_ctl,
    input wire logic [trace_attach_pkg::DATA_W-1:0] mem_rdata,
    input wire logic [trace_attach_pkg::DATA_W-1:0] core_wdata,
    input wire logic [trace_attach_pkg::DATA_W-1:0] copro_rdata,
    output logic [trace_attach_pkg::DATA_W-1:0] core_read_in,
    // trace unit data side
    output logic [trace_attach_pkg::DATA_W-1:0] read_data_bus,
    output logic [trace_attach_pkg::DATA_W-1:0] write_data_bus,
    output trace_attach_pkg::glue_state_s sel,
    output trace_attach_pkg::tie_s ties,
    output logic trace_state_reset_n,
    // debugger command side
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_reset,
    input wire logic [trace_attach_pkg::BIT_W-1:0] cmd_count,
    input wire logic [trace_attach_pkg::SHIFT_W-1:0] cmd_tms,
    input wire logic [trace_attach_pkg::SHIFT_W-1:0] cmd_tdi,
    output logic done,
    output logic [trace_attach_pkg::SHIFT_W-1:0] tdo_bits,
    // test access pins
    output trace_attach_pkg::tap_pins_s tap_out,
    input wire logic tdo
);
    trace_attach_pkg::top_state_s st_r;
    trace_attach_pkg::top_state_s st_nxt;
    logic rst_n;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rst_sync = {st_r.rst_sync[0], 1'b1};
        // test reset through two flops into this domain; core reset (resetn) also clears both flops
        st_nxt.trst_sync = {st_r.trst_sync[0], tap_out.test_reset_n}; // R14 R15
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r.rst_sync <= trace_attach_pkg::SYNC_CLEAR;
            st_r.trst_sync <= trace_attach_pkg::SYNC_CLEAR;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rst_n = st_r.rst_sync[1];
    assign trace_state_reset_n = st_r.trst_sync[1]; // R14

    // this core has neither instruction valid nor java trace outputs
    always_comb begin
        ties.instruction_valid_in = 1'b1; // R1
        ties.fetch_addr0 = 1'b0; // R9
        ties.java_state_bit = 1'b0; // R9
        ties.java_first_fetch = 1'b0; // R9
        ties.java_last_fetch = 1'b0; // R9
    end

    copro_select_glue u_glue (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .core_ctl(core_ctl),
        .mem_rdata(mem_rdata),
        .core_wdata(core_wdata),
        .copro_rdata(copro_rdata),
        .read_data_bus(read_data_bus),
        .write_data_bus(write_data_bus),
        .core_read_in(core_read_in),
        .sel(sel)
    );

    tap_sequencer u_seq (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready),
        .cmd_reset(cmd_reset),
        .cmd_count(cmd_count),
        .cmd_tms(cmd_tms),
        .cmd_tdi(cmd_tdi),
        .done(done),
        .tdo_bits(tdo_bits),
        .tap_out(tap_out),
        .tdo(tdo)
    );

    ties_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
        ties.instruction_valid_in && !ties.java_state_bit && !ties.fetch_addr0)
        else $error("absent core inputs not tied");
    java_ties_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
        !ties.java_first_fetch && !ties.java_last_fetch)
        else $error("java fetch markers not tied low");
    trst_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
        $fell(tap_out.test_reset_n) |-> trace_state_reset_n [*2] ##1 !trace_state_reset_n)
        else $error("trace state reset not two cycles behind test reset");
    trst_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
        $rose(tap_out.test_reset_n) |-> ##2 trace_state_reset_n)
        else $error("trace state reset not released after test reset");
    cover_trace_reset_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(trace_state_reset_n));
endmodule

// ### trace_unit_model.sv
// behavioural model of the trace unit seen from the host side
// assumes ref_clk is the trace unit main clock and tap pins come from the host
module trace_unit_model (
    // main domain
    input wire logic ref_clk,
    input wire logic core_clock_enable,
    input wire logic trace_state_reset_n,
    input wire trace_attach_pkg::core_ctl_s core_ctl,
    input wire logic [trace_attach_pkg::DATA_W-1:0] read_data_bus,
    input wire logic [trace_attach_pkg::DATA_W-1:0] write_data_bus,
    output logic [trace_attach_pkg::DATA_W-1:0] trace_word,
    output logic trace_valid,
    // test access
    input wire trace_attach_pkg::tap_pins_s tap_in,
    output logic tdo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] chain_sel_r;

    always @(posedge ref_clk or negedge trace_state_reset_n) begin
        if (!trace_state_reset_n) begin
            trace_word <= '0;
            trace_valid <= 1'b0;
        end else begin
            trace_valid <= core_clock_enable;
            if (core_clock_enable) begin
                if (!core_ctl.data_write_not_read || (!core_ctl.data_request_n && !core_ctl.condition_pass_flag)) begin
                    trace_word <= read_data_bus;
                end else begin
                    trace_word <= write_data_bus;
                end
            end
        end
    end

    // own chain never selected here, so data out is the pass-through path
    // test-domain state stays in its own domain, nothing crosses to the main clock
    always @(posedge tap_in.tck or negedge tap_in.test_reset_n) begin
        if (!tap_in.test_reset_n) begin
            chain_sel_r <= 4'h0;
            tdo <= 1'b0;
        end else if (tap_in.jtag_clock_enable) begin
            tdo <= (chain_sel_r == 4'h6) ? 1'b0 : tap_in.chain_expansion_in;
        end
    end
endmodule

// ### tb_trace_attach_host.sv
// self-checking bench for the trace attachment host
// assumes trace_unit_model stands in for the trace unit on the far side
module tb_trace_attach_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    trace_attach_pkg::core_ctl_s core_ctl = '0;
    logic [31:0] mem_rdata = '0, core_wdata = '0, copro_rdata = '0, core_read_in, read_data_bus, write_data_bus;
    trace_attach_pkg::glue_state_s sel;
    trace_attach_pkg::tie_s ties;
    trace_attach_pkg::tap_pins_s tap_out;
    logic trace_state_reset_n, cmd_ready, done, tdo, core_clock_enable = 1'b0;
    logic cmd_valid = 1'b0, cmd_reset = 1'b0, prev_tdo = 1'b0;
    logic [4:0] cmd_count = '0;
    logic [31:0] cmd_tms = '0, cmd_tdi = '0, tdo_bits, seed = 32'hB63771A4, r;
    int errors = 0;
    int comparisons = 0;

    trace_attach_host DUT (.ref_clk(ref_clk), .resetn(resetn), .core_ctl(core_ctl), .mem_rdata(mem_rdata),
        .core_wdata(core_wdata), .copro_rdata(copro_rdata), .core_read_in(core_read_in),
        .read_data_bus(read_data_bus), .write_data_bus(write_data_bus), .sel(sel), .ties(ties),
        .trace_state_reset_n(trace_state_reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_reset(cmd_reset), .cmd_count(cmd_count), .cmd_tms(cmd_tms), .cmd_tdi(cmd_tdi), .done(done),
        .tdo_bits(tdo_bits), .tap_out(tap_out), .tdo(tdo));
    trace_unit_model trace_unit (.ref_clk(ref_clk), .core_clock_enable(core_clock_enable),
        .trace_state_reset_n(trace_state_reset_n), .core_ctl(core_ctl), .read_data_bus(read_data_bus),
        .write_data_bus(write_data_bus), .trace_word(), .trace_valid(), .tap_in(tap_out), .tdo(tdo));

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
        return seed;
    endfunction

    // first captured bit is the data-out level left from the previous transfer
    function automatic logic [31:0] exp_tdo(input logic [4:0] cnt, input logic [31:0] tdi, input logic prev);
        logic [31:0] v;
        v = {tdi[30:0], prev};
        return v << (5'h1F - cnt);
    endfunction

    task automatic end_of_test();
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic glue_step(input logic [3:0] c);
        trace_attach_pkg::core_ctl_s p;
        logic rs, cs, qs;
        p = core_ctl;
        @(posedge ref_clk);
        r = rnd();
        core_ctl <= c;
        core_clock_enable <= r[31];
        mem_rdata <= r;
        core_wdata <= rnd();
        copro_rdata <= rnd();
        @(negedge ref_clk);
        rs = ~(p.data_request_n & p.data_sequential) & ~p.data_write_not_read;
        cs = ~p.data_request_n & ~p.condition_pass_flag;
        qs = p.data_request_n & p.data_sequential;
        chk("sel", sel, {rs, cs, qs});
        chk("read_bus", read_data_bus, rs ? copro_rdata : mem_rdata);
        chk("write_bus", write_data_bus, cs ? copro_rdata : core_wdata);
        chk("core_read", core_read_in, qs ? copro_rdata : mem_rdata);
        chk("ties", ties, 5'h10);
    endtask

    task automatic run_cmd(input logic rst, input logic [4:0] cnt, input logic [31:0] tms, input logic [31:0] tdi);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        if (cmd_ready !== 1'b1) begin
            chk("ready_wait", cmd_ready, 1'b1);
            end_of_test();
        end
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_reset <= rst;
        cmd_count <= cnt;
        cmd_tms <= tms;
        cmd_tdi <= tdi;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            @(negedge ref_clk);
            if (rst && tap_out.test_reset_n === 1'b0) chk("tms_tck", {tap_out.tms, tap_out.tck}, 2'h2);
            if (rst && n == trace_attach_pkg::TRST_HOLD_CYC + 1) chk("trace_rst_lo", trace_state_reset_n, 1'b0);
            if (rst && n == trace_attach_pkg::TRST_HOLD_CYC + 2) chk("trace_rst_hi", trace_state_reset_n, 1'b1);
        end while (done !== 1'b1 && n < 300);
        chk("done_cycle", n, rst ? trace_attach_pkg::TRST_HOLD_CYC + trace_attach_pkg::SETTLE_CYC
            : 2 * trace_attach_pkg::TCK_HALF_CYC * (int'(cnt) + 1));
        if (done !== 1'b1) end_of_test();
        chk("tck_enable", tap_out.jtag_clock_enable, 1'b1);
        if (!rst) begin
            chk("tdo_bits", tdo_bits, exp_tdo(cnt, tdi, prev_tdo));
            prev_tdo = tdi[cnt];
        end else begin
            prev_tdo = 1'b0;
        end
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 16; i++) glue_step(4'(i));
        repeat (200) glue_step(4'(rnd() >> 28));
        run_cmd(1'b1, 5'h00, 32'h00000000, 32'h00000000);
        run_cmd(1'b0, 5'h00, 32'h00000000, 32'h00000001);
        run_cmd(1'b0, 5'h1F, rnd(), rnd());
        repeat (4) begin
            r = rnd();
            run_cmd(1'b0, r[4:0], rnd(), rnd());
        end
        run_cmd(1'b1, 5'h00, 32'h00000000, 32'h00000000);
        run_cmd(1'b0, 5'h1F, 32'h00000000, 32'hFFFFFFFF);
        end_of_test();
    end
endmodule
